/* File: rcc_defs.svh */
`ifndef RCC_DEFS_SVH
`define RCC_DEFS_SVH

`define RCC_ADDR_W 4
`define RCC_OFS_SELECT 4'h8
`define RCC_OFS_CIRCUIT 4'h9
`define RCC_OFS_MASK 4'hA
`define RCC_OFS_STATUS 4'hB
`define RCC_OFS_FLAGS 4'hC
`define RCC_RST_SELECT 8'h18
`define RCC_RST_CIRCUIT 8'hFF
`define RCC_RST_MASK 8'h00
`define RCC_RST_STATUS 8'h00
`define RCC_BIT_AUX_SRC 3
`define RCC_BIT_AUX_EN 4
`define RCC_BIT_FILL 5
`define RCC_BIT_IGNORE 6
`define RCC_BIT_MCLK_SRC 7
`define RCC_CAUSE_UNLOCK 0
`define RCC_CAUSE_INVALID 1
`define RCC_CAUSE_CSUD 2
`define RCC_CAUSE_TRANS 3
`define RCC_CAUSE_NONPCM 4
`define RCC_CAUSE_COPY 5
`define RCC_CAUSE_EMPH 6
`define RCC_CAUSE_RATE 7
`define RCC_ZERO_SAMPLE 24'h000000

`endif

/* File: rcc_pkg.sv */
package rcc_pkg;
    typedef struct packed {
        logic [2:0] rx_input_select;
    } rcc_sel_t;

    typedef struct packed {
        logic master_clock_out_source;
        logic ignore_invalid_select;
        logic corrupt_data_fill_select;
        logic aux_clock_pin_enable;
        logic aux_clock_out_source;
        logic [2:0] rx_input_select;
    } rcc_select_reg_t;

    typedef struct packed {
        logic unlock;
        logic invalid;
        logic chan_status_update;
        logic transmission_error;
        logic nonpcm;
        logic copyright;
        logic emphasis;
        logic [1:0] rate;
    } rcc_rx_flags_t;
endpackage

/* File: rcc_sample_hold.sv */
`timescale 1ns/10ps
`include "rcc_defs.svh"

module rcc_sample_hold #(
    parameter int WIDTH = 24
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_valid,
    input wire logic i_bad,
    input wire logic i_fill_zero,
    input wire logic [WIDTH-1:0] i_sample,
    output logic [WIDTH-1:0] o_sample
);
    logic [WIDTH-1:0] out_reg;
    logic [WIDTH-1:0] out_next;

    always_comb begin
        out_next = out_reg;
        if (i_valid) begin
            if (!i_bad) begin
                out_next = i_sample;
            end else if (i_fill_zero) begin
                out_next = WIDTH'(`RCC_ZERO_SAMPLE);
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            out_reg <= '0;
        end else begin
            out_reg <= out_next;
        end
    end

    assign o_sample = out_reg;
endmodule

/* File: rcc_config.sv */
// Summary of operation
// - Select field routes one of eight inputs
// - Aux clock source: PLL one or oscillator
// - Aux clock pin enable, reset driven
// - Corrupt data holds last or zeros
// - Ignore-invalid bit disregards invalid flag
// - Master clock source: PLL two or oscillator
// - Per-input circuit type, reset all comparator
// - Mask bit blocks status and interrupt
// - Mask bit order unlock through rate
// - Read-only status shows interrupt causes
// - Unlock flag high while not locked
`timescale 1ns/10ps
`include "rcc_defs.svh"

module rcc_config #(
    parameter int SAMPLE_W = 24
) (
    input wire logic I_MCLK,
    input wire logic I_RESETN,
    // Control port register access
    input wire logic I_WR_EN,
    input wire logic I_RD_EN,
    input wire logic [`RCC_ADDR_W-1:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    output logic [7:0] O_RDATA,
    // Receiver inputs and status
    input wire logic [7:0] I_RX,
    input wire rcc_pkg::rcc_rx_flags_t I_FLAGS,
    input wire logic I_SAMPLE_VALID,
    input wire logic I_SAMPLE_CORRUPT,
    input wire logic [SAMPLE_W-1:0] I_SAMPLE,
    output logic [SAMPLE_W-1:0] O_SAMPLE,
    output logic O_RX_DATA,
    output logic [7:0] O_COMPARATOR_SEL,
    // Clocks and interrupt
    input wire logic I_PLL_CLOCK_ONE,
    input wire logic I_PLL_CLOCK_TWO,
    input wire logic I_OSCILLATOR_CLOCK,
    output logic O_AUX_CLOCK_PIN,
    output logic O_AUX_CLOCK_PIN_OE_N,
    output logic O_MASTER_CLOCK,
    output logic O_INT_N
);
    // =====================================================
    // Register state
    rcc_pkg::rcc_select_reg_t sel_reg;
    rcc_pkg::rcc_select_reg_t sel_next;
    logic [7:0] circuit_reg;
    logic [7:0] circuit_next;
    logic [7:0] mask_reg;
    logic [7:0] mask_next;
    logic [7:0] status_reg;
    logic [7:0] status_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    rcc_pkg::rcc_rx_flags_t flags_prev_reg;
    logic [7:0] cause;
    logic [7:0] raw_event;
    logic status_read;

    always_comb begin
        sel_next = sel_reg;
        circuit_next = circuit_reg;
        mask_next = mask_reg;
        if (I_WR_EN) begin
            unique case (I_ADDR)
                `RCC_OFS_SELECT: begin
                    sel_next = rcc_pkg::rcc_select_reg_t'(I_WDATA);
                end
                `RCC_OFS_CIRCUIT: begin
                    circuit_next = I_WDATA;
                end
                `RCC_OFS_MASK: begin
                    mask_next = I_WDATA;
                end
                default: begin
                end
            endcase
        end
    end

    // =====================================================
    // Interrupt causes
    // Toggles detected against last cycle's flags; invalid,
    // channel status update and transmission error are levels.
    always_comb begin
        raw_event = 8'h00;
        raw_event[`RCC_CAUSE_UNLOCK] = I_FLAGS.unlock ^ flags_prev_reg.unlock;
        raw_event[`RCC_CAUSE_INVALID] = I_FLAGS.invalid & ~sel_reg.ignore_invalid_select;
        raw_event[`RCC_CAUSE_CSUD] = I_FLAGS.chan_status_update;
        raw_event[`RCC_CAUSE_TRANS] = I_FLAGS.transmission_error;
        raw_event[`RCC_CAUSE_NONPCM] = I_FLAGS.nonpcm ^ flags_prev_reg.nonpcm;
        raw_event[`RCC_CAUSE_COPY] = I_FLAGS.copyright ^ flags_prev_reg.copyright;
        raw_event[`RCC_CAUSE_EMPH] = I_FLAGS.emphasis ^ flags_prev_reg.emphasis;
        raw_event[`RCC_CAUSE_RATE] = |(I_FLAGS.rate ^ flags_prev_reg.rate);
    end

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_cause
            assign cause[gi] = raw_event[gi] & ~mask_reg[gi];
        end
    endgenerate

    assign status_read = I_RD_EN && (I_ADDR == `RCC_OFS_STATUS);

    // Read clears the status; a cause in the same cycle still sets
    always_comb begin
        status_next = status_read ? (`RCC_RST_STATUS | cause) : (status_reg | cause);
    end

    // =====================================================
    // Read path
    always_comb begin
        rdata_next = rdata_reg;
        if (I_RD_EN) begin
            unique case (I_ADDR)
                `RCC_OFS_SELECT: rdata_next = sel_reg;
                `RCC_OFS_CIRCUIT: rdata_next = circuit_reg;
                `RCC_OFS_MASK: rdata_next = mask_reg;
                `RCC_OFS_STATUS: rdata_next = status_reg;
                `RCC_OFS_FLAGS: rdata_next = {1'b0, I_FLAGS.unlock, I_FLAGS.rate,
                    I_FLAGS.emphasis, I_FLAGS.copyright, I_FLAGS.nonpcm, 1'b0};
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge I_MCLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            sel_reg <= rcc_pkg::rcc_select_reg_t'(`RCC_RST_SELECT);
            circuit_reg <= `RCC_RST_CIRCUIT;
            mask_reg <= `RCC_RST_MASK;
            status_reg <= `RCC_RST_STATUS;
            rdata_reg <= 8'h00;
            flags_prev_reg <= '0;
        end else begin
            sel_reg <= sel_next;
            circuit_reg <= circuit_next;
            mask_reg <= mask_next;
            status_reg <= status_next;
            rdata_reg <= rdata_next;
            flags_prev_reg <= I_FLAGS;
        end
    end

    // =====================================================
    // Datapath outputs
    assign O_RDATA = rdata_reg;
    assign O_RX_DATA = I_RX[sel_reg.rx_input_select];
    assign O_COMPARATOR_SEL = circuit_reg;
    // Clock muxes are combinational; glitch-free switching is left to the clock cells
    assign O_AUX_CLOCK_PIN = sel_reg.aux_clock_out_source ? I_OSCILLATOR_CLOCK
        : I_PLL_CLOCK_ONE;
    assign O_AUX_CLOCK_PIN_OE_N = ~sel_reg.aux_clock_pin_enable;
    assign O_MASTER_CLOCK = sel_reg.master_clock_out_source ? I_OSCILLATOR_CLOCK
        : I_PLL_CLOCK_TWO;
    assign O_INT_N = ~(|status_reg);

    logic sample_bad;
    assign sample_bad = I_SAMPLE_CORRUPT
        | (I_FLAGS.invalid & ~sel_reg.ignore_invalid_select);

    rcc_sample_hold #(
        .WIDTH(SAMPLE_W)
    ) u_hold (
        .i_clk(I_MCLK),
        .i_resetn(I_RESETN),
        .i_valid(I_SAMPLE_VALID),
        .i_bad(sample_bad),
        .i_fill_zero(sel_reg.corrupt_data_fill_select),
        .i_sample(I_SAMPLE),
        .o_sample(O_SAMPLE)
    );
endmodule

/* File: rcc_config_sva.sv */
`timescale 1ns/10ps
`include "rcc_defs.svh"
// ============================================================
// Port checks
module rcc_config_sva #(
    parameter int SAMPLE_W = 24
) (
    input wire logic I_MCLK,
    input wire logic I_RESETN,
    input wire logic I_WR_EN,
    input wire logic I_RD_EN,
    input wire logic [`RCC_ADDR_W-1:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic [7:0] O_RDATA,
    input wire logic [7:0] I_RX,
    input wire rcc_pkg::rcc_rx_flags_t I_FLAGS,
    input wire logic I_SAMPLE_VALID,
    input wire logic I_SAMPLE_CORRUPT,
    input wire logic [SAMPLE_W-1:0] I_SAMPLE,
    input wire logic [SAMPLE_W-1:0] O_SAMPLE,
    input wire logic O_RX_DATA,
    input wire logic [7:0] O_COMPARATOR_SEL,
    input wire logic I_PLL_CLOCK_TWO,
    input wire logic I_OSCILLATOR_CLOCK,
    input wire logic O_AUX_CLOCK_PIN_OE_N,
    input wire logic O_MASTER_CLOCK
);
    logic [7:0] sel_reg;
    logic [7:0] sel_next;
    // Shadow of the select register, seen only through writes
    always_comb sel_next = (I_WR_EN && I_ADDR == `RCC_OFS_SELECT) ? I_WDATA : sel_reg;
    always_ff @(posedge I_MCLK or negedge I_RESETN) begin
        if (!I_RESETN) sel_reg <= `RCC_RST_SELECT;
        else sel_reg <= sel_next;
    end
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_RESETN);
    a_rx_route: assert property (O_RX_DATA == I_RX[sel_reg[2:0]])
        else $error("receiver input route wrong");
    a_mclk_src: assert property (O_MASTER_CLOCK == (sel_reg[7] ? I_OSCILLATOR_CLOCK : I_PLL_CLOCK_TWO))
        else $error("master clock source wrong");
    a_aux_drive: assert property (O_AUX_CLOCK_PIN_OE_N == !sel_reg[4])
        else $error("aux pin drive wrong");
    a_circ_read: assert property (I_RD_EN && I_ADDR == `RCC_OFS_CIRCUIT |=> O_RDATA == $past(O_COMPARATOR_SEL))
        else $error("circuit type readback wrong");
    a_rdata_hold: assert property (!I_RD_EN |=> $stable(O_RDATA))
        else $error("read data moved without a read");
    a_fill_zero: assert property (I_SAMPLE_VALID && I_SAMPLE_CORRUPT && sel_reg[5] |=> O_SAMPLE == '0)
        else $error("corrupt sample not zeroed");
    a_hold_last: assert property (I_SAMPLE_VALID && I_SAMPLE_CORRUPT && !sel_reg[5] |=> $stable(O_SAMPLE))
        else $error("corrupt sample not held");
    a_good_load: assert property (I_SAMPLE_VALID && !I_SAMPLE_CORRUPT && (!I_FLAGS.invalid || sel_reg[6])
        |=> O_SAMPLE == $past(I_SAMPLE))
        else $error("good sample not loaded");
endmodule
bind rcc_config rcc_config_sva #(.SAMPLE_W(SAMPLE_W)) sva_u (.I_MCLK, .I_RESETN, .I_WR_EN, .I_RD_EN,
    .I_ADDR, .I_WDATA, .O_RDATA, .I_RX, .I_FLAGS, .I_SAMPLE_VALID, .I_SAMPLE_CORRUPT, .I_SAMPLE,
    .O_SAMPLE, .O_RX_DATA, .O_COMPARATOR_SEL, .I_PLL_CLOCK_TWO, .I_OSCILLATOR_CLOCK,
    .O_AUX_CLOCK_PIN_OE_N, .O_MASTER_CLOCK);

/* File: rcc_host.sv */
`timescale 1ns/10ps
// ============================================================
// Host on the control port
module rcc_host (
    input wire logic clk,
    input wire logic [7:0] rdata,
    output logic wr,
    output logic rd,
    output logic [3:0] addr,
    output logic [7:0] wdata
);
    initial begin
        {wr, rd, addr, wdata} = 14'h0000;
    end
    task automatic access(input logic w, input logic [3:0] a, input logic [7:0] d,
                          output logic [7:0] q);
        @(posedge clk);
        #1;
        {wr, rd, addr, wdata} = {w, !w, a, d};
        @(posedge clk);
        #1;
        {wr, rd} = 2'h0;
        wdata = ~d; // Stale data must never look valid
        q = rdata;
    endtask
endmodule

/* File: testbench.sv */
`timescale 1ns/10ps
`include "rcc_defs.svh"
module testbench;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic [7:0] rx = 8'h00;
    logic [2:0] ck = 3'h0;
    logic [8:0] fl = 9'h000;
    logic sv = 1'h0;
    logic sc = 1'h0;
    logic [23:0] smp = 24'h000000;
    logic [23:0] osmp;
    logic [23:0] expv = 24'h000000;
    logic wr, rd, rxd, oe_n, mck, aux, int_n, fill, ign;
    logic [3:0] addr;
    logic [7:0] wd, rdat, comp, q, sel, circ;
    logic [15:0] r = 16'h0002;
    int err_total = 0;
    int checked = 0;
    rcc_host host_u (.clk(clk), .rdata(rdat), .wr(wr), .rd(rd), .addr(addr), .wdata(wd));
    rcc_config dut_u (.I_MCLK(clk), .I_RESETN(rst_n), .I_WR_EN(wr), .I_RD_EN(rd), .I_ADDR(addr),
        .I_WDATA(wd), .O_RDATA(rdat), .I_RX(rx), .I_FLAGS(fl), .I_SAMPLE_VALID(sv),
        .I_SAMPLE_CORRUPT(sc), .I_SAMPLE(smp), .O_SAMPLE(osmp), .O_RX_DATA(rxd),
        .O_COMPARATOR_SEL(comp), .I_PLL_CLOCK_ONE(ck[0]), .I_PLL_CLOCK_TWO(ck[1]),
        .I_OSCILLATOR_CLOCK(ck[2]), .O_AUX_CLOCK_PIN(aux), .O_AUX_CLOCK_PIN_OE_N(oe_n),
        .O_MASTER_CLOCK(mck), .O_INT_N(int_n));
    initial forever #5 clk = ~clk;
    initial begin
        #100000;
        err_total++;
        tally_and_finish();
    end
    function automatic logic [15:0] nx(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic chk(input string n, input logic [23:0] s, input logic [23:0] e);
        checked++;
        if (s !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wrr(input logic [3:0] a, input logic [7:0] d);
        host_u.access(1'h1, a, d, q);
    endtask
    task automatic rdc(input logic [3:0] a, input logic [7:0] e);
        host_u.access(1'h0, a, 8'h00, q);
        chk("rdata", q, e);
    endtask
    // Two flips of one flag: a pulse for level causes, two toggles otherwise
    task automatic cause(input int i);
        repeat (2) begin
            @(posedge clk);
            #1 fl[(i == 7) ? 0 : 8 - i] ^= 1'h1;
        end
        repeat (3) @(posedge clk);
    endtask
    task automatic send(input logic c, input logic inv);
        r = nx(r);
        @(posedge clk);
        #1 {sv, sc, fl[7], smp} = {1'h1, c, inv, r, r[7:0]};
        @(posedge clk);
        #1 {sv, fl[7]} = 2'h0;
        expv = (c || (inv && !ign)) ? (fill ? 24'h000000 : expv) : smp;
        chk("sample", osmp, expv);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // ============================================================
    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        #1 rst_n = 1'h1;
        rdc(`RCC_OFS_SELECT, `RCC_RST_SELECT);
        rdc(`RCC_OFS_CIRCUIT, 8'hFF);
        rdc(`RCC_OFS_MASK, 8'h00);
        rdc(4'h3, 8'h00);
        chk("int_n", int_n, 1'h1);
        $display("test reset done");
        for (int n = 0; n < 8; n++) begin
            r = nx(r);
            sel = {r[7:3], 3'(n)};
            wrr(`RCC_OFS_SELECT, sel);
            circ = r[15:8];
            wrr(`RCC_OFS_CIRCUIT, circ);
            r = nx(r);
            {ck, rx} = r[10:0];
            #1 chk("rx_data", rxd, rx[n]);
            chk("mclk", mck, sel[7] ? ck[2] : ck[1]);
            chk("aux", aux, sel[3] ? ck[2] : ck[0]);
            chk("oe_n", oe_n, !sel[4]);
            chk("circuit", comp, circ);
            rdc(`RCC_OFS_SELECT, sel);
            rdc(`RCC_OFS_CIRCUIT, circ);
        end
        $display("test routing done");
        wrr(`RCC_OFS_SELECT, 8'h18);
        for (int i = 0; i < 8; i++) begin
            wrr(`RCC_OFS_MASK, ~(8'h01 << i));
            cause(i);
            chk("int_n", int_n, 1'h0);
            rdc(`RCC_OFS_STATUS, 8'h01 << i);
            @(posedge clk);
            #1 chk("int_n", int_n, 1'h1);
            wrr(`RCC_OFS_MASK, 8'h01 << i);
            cause(i);
            rdc(`RCC_OFS_STATUS, 8'h00);
        end
        wrr(`RCC_OFS_SELECT, 8'h58);
        wrr(`RCC_OFS_MASK, 8'h00);
        cause(1);
        rdc(`RCC_OFS_STATUS, 8'h00);
        // Live flags: unlock, rate 01, emphasis and non-PCM set
        fl = 9'h115;
        rdc(`RCC_OFS_FLAGS, 8'h5A);
        $display("test mask done");
        for (int f = 0; f < 4; f++) begin
            {ign, fill} = 2'(f);
            wrr(`RCC_OFS_SELECT, {1'h0, ign, fill, 5'h18});
            send(1'h0, 1'h0);
            send(1'h1, 1'h0);
            send(1'h0, 1'h1);
        end
        $display("test sample done");
        tally_and_finish();
    end
endmodule
